// file: src/rsqcc_top.sv
// reset sequence manager with core clock selection
`timescale 1ns/1ps
module rsqcc_top
	import rsqcc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// reset pin, open drain
	input wire logic rst_pin_n_in,
	output logic rst_pin_low_out,
	output logic rst_pin_oe_out,
	// internal sources
	input wire logic low_supply_detector_in,
	input wire logic wdg_underflow_in,
	input wire logic usb_supply_pin_in,
	input wire logic pll_lock_in,
	// prescaler control
	input wire logic core_clock_divider_enable_in,
	input wire logic [1:0] core_clock_divider_sel_in,
	// core side
	output logic core_rst_out,
	output logic vec_fetch_out,
	output logic [15:0] vec_addr_out,
	output logic usb_mode_out,
	output logic pll_en_out,
	output logic core_clk_out
);
	rsqcc_state_e state_q;
	logic pin_lat_q;
	logic pin_s1_q, pin_s2_q;
	logic lat_s1_q, lat_s2_q;
	logic [1:0] own_q;
	logic pin_src;
	logic sup_s1_q, sup_s2_q, sup_q;
	logic usb_s1_q, usb_s2_q;
	logic lock_s1_q, lock_s2_q;
	logic [7:0] filt_q;
	logic [7:0] stretch_q;
	logic [9:0] dly_q;
	logic [1:0] fetch_q;
	logic pin_clr;
	logic src_any;
	logic wdg_q;
	logic usb_q;

	// pin low is latched with no clock, so a halted core still enters reset;
	// the active phase has taken the request, so the latch is cleared there
	assign pin_clr = sys_rst_in | (state_q == RSQCC_ACTIVE);
	always_ff @(negedge rst_pin_n_in or posedge pin_clr) begin
		if (pin_clr) begin
			pin_lat_q <= 1'b0;
		end else begin
			pin_lat_q <= 1'b1;
		end
	end

	// synchronisers for everything from outside this clock
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			lat_s1_q <= 1'b0;
			lat_s2_q <= 1'b0;
			sup_s1_q <= 1'b1;
			sup_s2_q <= 1'b1;
			usb_s1_q <= 1'b0;
			usb_s2_q <= 1'b0;
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= ~rst_pin_n_in;
			pin_s2_q <= pin_s1_q;
			lat_s1_q <= pin_lat_q;
			lat_s2_q <= lat_s1_q;
			sup_s1_q <= low_supply_detector_in;
			sup_s2_q <= sup_s1_q;
			usb_s1_q <= usb_supply_pin_in;
			usb_s2_q <= usb_s1_q;
			lock_s1_q <= pll_lock_in;
			lock_s2_q <= lock_s1_q;
		end
	end

	// supply flag changes only after a steady level; detector thresholds give hysteresis
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			filt_q <= 8'h0;
			sup_q <= 1'b1;
		end else if (sup_s2_q == sup_q) begin
			filt_q <= 8'h0;
		end else if (filt_q + 8'h1 >= SUP_FILT_CYC) begin
			filt_q <= 8'h0;
			sup_q <= sup_s2_q;
		end else begin
			filt_q <= filt_q + 8'h1;
		end
	end

	// watchdog pulse is held until the active phase has consumed it
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wdg_q <= 1'b0;
		end else if (wdg_underflow_in) begin
			wdg_q <= 1'b1;
		end else if (state_q == RSQCC_ACTIVE && stretch_q == 8'h0) begin
			wdg_q <= 1'b0;
		end
	end

	// usb mode sampled in the active phase only, so the delay length cannot change midway
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			usb_q <= 1'b0;
		end else if (state_q == RSQCC_ACTIVE) begin
			usb_q <= usb_s2_q;
		end
	end

	// our own drive reads back low on the wire, so the pin sense stays blind
	// until two synchroniser stages have flushed it; a pull from outside while
	// we drive is not seen, which is harmless as the device is in reset anyway
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			own_q <= 2'h3;
		end else begin
			own_q <= {own_q[0], rst_pin_oe_out};
		end
	end
	assign pin_src = (pin_s2_q | lat_s2_q) & ~(rst_pin_oe_out | own_q[0] | own_q[1]);

	assign src_any = pin_src | sup_q | wdg_underflow_in;

	// phase sequencer
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= RSQCC_ACTIVE;
			stretch_q <= OUT_RST_CYC;
			dly_q <= 10'h0;
			fetch_q <= 2'h0;
		end else if (src_any && state_q != RSQCC_ACTIVE) begin
			state_q <= RSQCC_ACTIVE;
			stretch_q <= OUT_RST_CYC;
			dly_q <= 10'h0;
		end else begin
			unique case (state_q)
				RSQCC_ACTIVE: begin
					if (stretch_q != 8'h0) begin
						stretch_q <= stretch_q - 8'h1;
					end else if (!src_any && !wdg_q) begin
						state_q <= RSQCC_DELAY;
						dly_q <= 10'h0;
					end
				end
				RSQCC_DELAY: begin
					if (!usb_q || lock_s2_q) begin
						dly_q <= dly_q + 10'h1;
					end
					if (dly_q + 10'h1 == (usb_q ? DLY_USB_CYC : DLY_SA_CYC) &&
						(!usb_q || lock_s2_q)) begin
						state_q <= RSQCC_FETCH;
						fetch_q <= 2'h0;
					end
				end
				RSQCC_FETCH: begin
					fetch_q <= fetch_q + 2'h1;
					if (fetch_q + 2'h1 == FETCH_CYC) begin
						state_q <= RSQCC_RUN;
					end
				end
				RSQCC_RUN: begin
					state_q <= RSQCC_RUN;
				end
			endcase
		end
	end

	// outputs registered; pin is driven low in active and delay phases
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rst_pin_low_out <= 1'b0;
			rst_pin_oe_out <= 1'b1;
			core_rst_out <= 1'b1;
			vec_fetch_out <= 1'b0;
			vec_addr_out <= VEC_HI_ADDR;
			usb_mode_out <= 1'b0;
			pll_en_out <= 1'b0;
		end else begin
			rst_pin_low_out <= 1'b0;
			rst_pin_oe_out <= (state_q == RSQCC_ACTIVE) || (state_q == RSQCC_DELAY);
			core_rst_out <= (state_q != RSQCC_RUN);
			vec_fetch_out <= (state_q == RSQCC_FETCH);
			vec_addr_out <= (fetch_q == 2'h0) ? VEC_HI_ADDR : VEC_LO_ADDR;
			usb_mode_out <= usb_q;
			pll_en_out <= usb_q;
		end
	end

	rsqcc_clkdiv u_div (
		.clk_in(clk_in),
		.rst_in(sys_rst_in),
		.usb_mode_in(usb_q),
		.core_clock_divider_enable_in(core_clock_divider_enable_in),
		.core_clock_divider_sel_in(core_clock_divider_sel_in),
		.core_clk_out(core_clk_out)
	);

	pin_low_delay_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state_q == RSQCC_DELAY |=> rst_pin_oe_out) else $error("pin released in delay");
	fetch_two_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(state_q == RSQCC_FETCH) && !src_any |=> state_q == RSQCC_FETCH ##1
		state_q == RSQCC_RUN || src_any) else $error("fetch not two cycles");
	fetch_vector_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		vec_fetch_out |-> vec_addr_out[15:1] == 15'h7FFF) else $error("bad vector address");
	delay_order_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state_q == RSQCC_FETCH |-> $past(state_q) != RSQCC_ACTIVE) else $error("delay skipped");
	usb_lock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		state_q == RSQCC_DELAY && usb_q && !lock_s2_q |=> $stable(dly_q) || state_q != RSQCC_DELAY)
		else $error("usb delay counted without lock");
	sa_delay_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(state_q == RSQCC_FETCH) && !usb_q |-> $past(dly_q) == 10'h1FF)
		else $error("stand-alone delay wrong");
	stretch_min_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$rose(state_q == RSQCC_DELAY) |-> $past(stretch_q) == 8'h0) else $error("pin not stretched");
	restart_src_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		src_any && state_q != RSQCC_ACTIVE |=> state_q == RSQCC_ACTIVE)
		else $error("source did not restart");
	wdg_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wdg_underflow_in |=> state_q == RSQCC_ACTIVE ##1 rst_pin_oe_out) else $error("watchdog ignored");
endmodule

// file: src/rsqcc_pkg.sv
// constants and types shared by the reset sequencer and clock divider
// Summary of operation
// - pin, supply and watchdog sources drive pin low
// - vector fetched from FFFEh and FFFFh
// - active, delay, then vector fetch, in order
// - stand-alone delay lasts 512 oscillator clocks
// - usb delay 256 clocks after pll lock
// - vector fetch lasts exactly two clocks
// - reset pin is input and open-drain output
// - pin reset recognised without core clock
// - pin driven low at least minimum output width
// - low supply holds reset with hysteresis thresholds
// - supply glitches shorter than filter are ignored
// - watchdog underflow drives pin low minimum width
// - core clock divided from oscillator by prescaler
// - usb mode up to 8 MHz, else 6
// - core clock is square wave, 50% duty
// - usb supply presence selects pll and usb
package rsqcc_pkg;
	localparam int unsigned CLK_MHZ = 25;
	localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE;
	localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF;
	localparam logic [9:0] DLY_SA_CYC = 10'h200;
	localparam logic [9:0] DLY_USB_CYC = 10'h100;
	localparam logic [1:0] FETCH_CYC = 2'h2;
	// minimum output reset width, in ns, and its clock count (rounded up)
	localparam int unsigned OUT_RST_NS = 1000;
	localparam logic [7:0] OUT_RST_CYC = 8'((OUT_RST_NS * CLK_MHZ + 999) / 1000);
	// supply spike filter time, in ns, and its count (longest time rounds down)
	localparam int unsigned SUP_FILT_NS = 400;
	localparam logic [7:0] SUP_FILT_CYC = 8'((SUP_FILT_NS * CLK_MHZ) / 1000);
	localparam logic [1:0] DIV_SEL_RST = 2'h0;
	typedef enum logic [1:0] {RSQCC_ACTIVE, RSQCC_DELAY, RSQCC_FETCH, RSQCC_RUN} rsqcc_state_e;
endpackage

// file: src/rsqcc_clkdiv.sv
// core clock prescaler producing a 50% duty square wave
`timescale 1ns/1ps
module rsqcc_clkdiv
	import rsqcc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// control
	input wire logic usb_mode_in,
	input wire logic core_clock_divider_enable_in,
	input wire logic [1:0] core_clock_divider_sel_in,
	// output
	output logic core_clk_out
);
	logic [4:0] cnt_q;
	logic [4:0] half_d;
	logic clk_q;

	// half period in oscillator cycles; usb mode osc 48 MHz caps at 8, stand-alone 12 at 6
	always_comb begin
		if (!core_clock_divider_enable_in) begin
			half_d = usb_mode_in ? 5'h3 : 5'h1;
		end else begin
			half_d = usb_mode_in ? 5'(5'h3 << core_clock_divider_sel_in) :
				5'(5'h1 << core_clock_divider_sel_in);
		end
	end

	// equal high and low halves keep the duty at 50%
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 5'h0;
			clk_q <= 1'b0;
		end else if (cnt_q + 5'h1 >= half_d) begin
			cnt_q <= 5'h0;
			clk_q <= ~clk_q;
		end else begin
			cnt_q <= cnt_q + 5'h1;
		end
	end
	assign core_clk_out = clk_q;

	// a half of one cycle is legal, so bound the counter instead of a minimum pulse length
	half_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$stable(half_d) |-> cnt_q < half_d) else $error("core clock half period overrun");
endmodule

// file: test/rsqcc_pin_model.sv
// board circuit that pulls the shared reset wire low on request
`timescale 1ns/1ps
module rsqcc_pin_model (
	// clock
	input wire logic clk_in,
	// request from the bench
	input wire logic pull_go_in,
	input wire logic [7:0] pull_cyc_in,
	// high while this circuit pulls the wire low
	output logic pull_out
);
	logic [7:0] left_q = 8'h00;
	// holds the wire for the requested count; a new request reloads the count from pull_cyc_in
	always @(posedge clk_in) begin
		if (pull_go_in) begin
			left_q <= pull_cyc_in;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	// open drain: only ever pulls low, the pull-up does the rest
	assign pull_out = (left_q != 8'h00);
endmodule

// file: test/rsqcc_top_tb.sv
// self-checking bench for the reset sequencer and core clock divider
`timescale 1ns/1ps
module rsqcc_top_tb;
	import rsqcc_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic lsd = 1'b0, wdg = 1'b0, usb = 1'b0, lock = 1'b0, en = 1'b0, go = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [7:0] pcyc = 8'h00;
	logic pin_n, pin_low, oe, crst, vf, usbm, plle, cclk, ext;
	logic [15:0] vaddr;
	int mismatches = 0, checks_done = 0, cyc = 0, oe_len, h, l, k;
	// wired-and with pull-up: idle wire reads high
	assign pin_n = !((oe && !pin_low) || ext);
	always #20 clk_in = ~clk_in;
	rsqcc_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .rst_pin_n_in(pin_n),
		.rst_pin_low_out(pin_low), .rst_pin_oe_out(oe), .low_supply_detector_in(lsd),
		.wdg_underflow_in(wdg), .usb_supply_pin_in(usb), .pll_lock_in(lock),
		.core_clock_divider_enable_in(en), .core_clock_divider_sel_in(sel),
		.core_rst_out(crst), .vec_fetch_out(vf), .vec_addr_out(vaddr),
		.usb_mode_out(usbm), .pll_en_out(plle), .core_clk_out(cclk));
	rsqcc_pin_model ext_u (.clk_in(clk_in), .pull_go_in(go), .pull_cyc_in(pcyc), .pull_out(ext));
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// a hang is cut short well past the longest expected run
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_cnt(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask
	// waits for the pin drive, then counts how long it stands
	task automatic measure;
		int w;
		w = 0;
		oe_len = 0;
		while (oe !== 1'b1 && w < 20) begin tick(1); w++; end
		while (oe === 1'b1 && oe_len < 3000) begin tick(1); oe_len++; end
	endtask
	// vector pair, two fetch cycles, then the core is let go
	task automatic fetch_check;
		int w;
		w = 0;
		while (vf !== 1'b1 && w < 10) begin tick(1); w++; end
		chk_val(vaddr, VEC_HI_ADDR);
		tick(1);
		chk_val({vf, vaddr}, {1'b1, VEC_LO_ADDR});
		tick(1);
		chk_val({15'h0, vf}, 16'h0);
		tick(2);
		chk_val({15'h0, crst}, 16'h0);
	endtask
	task automatic pulse_wdg;
		wdg = 1'b1;
		tick(1);
		wdg = 1'b0;
	endtask
	// length of the next full run of the core clock at level v
	task automatic run_len(input logic v, output int n);
		n = 0;
		while (cclk === v && n < 100) begin tick(1); n++; end
		n = 0;
		while (cclk !== v && n < 100) begin tick(1); n++; end
		n = 0;
		while (cclk === v && n < 100) begin tick(1); n++; end
	endtask
	initial begin
		void'($urandom(32'h32B5));
		tick(15);
		chk_val({14'h0, oe, crst}, 16'h3);
		tick(2);
		sys_rst_in = 1'b0;
		measure;
		chk_cnt(oe_len, 512, 560);
		chk_val({15'h0, pin_low}, 16'h0);
		fetch_check;
		pulse_wdg;
		measure;
		chk_cnt(oe_len, 537, 549);
		fetch_check;
		pcyc = 8'($urandom_range(3, 10));
		go = 1'b1;
		tick(1);
		go = 1'b0;
		measure;
		chk_cnt(oe_len, 537, 549);
		fetch_check;
		pcyc = 8'h3C;
		go = 1'b1;
		tick(1);
		go = 1'b0;
		measure;
		chk_cnt(oe_len, 537, 549);
		fetch_check;
		usb = 1'b1;
		k = $urandom_range(100, 200);
		pulse_wdg;
		fork
			measure;
			begin tick(k); lock = 1'b1; end
		join
		chk_cnt(oe_len, k + 254, k + 270);
		chk_val({14'h0, usbm, plle}, 16'h3);
		fetch_check;
		usb = 1'b0;
		lock = 1'b0;
		pulse_wdg;
		measure;
		chk_cnt(oe_len, 537, 549);
		chk_val({14'h0, usbm, plle}, 16'h0);
		fetch_check;
		lsd = 1'b1;
		tick($urandom_range(1, 6));
		lsd = 1'b0;
		tick(20);
		chk_val({15'h0, oe}, 16'h0);
		lsd = 1'b1;
		tick($urandom_range(20, 40));
		chk_val({15'h0, oe}, 16'h1);
		lsd = 1'b0;
		measure;
		chk_cnt(oe_len, 512, 560);
		fetch_check;
		pulse_wdg;
		fork
			measure;
			begin tick(300); pulse_wdg; end
		join
		chk_cnt(oe_len, 835, 851);
		fetch_check;
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				usb = 1'b1;
				lock = 1'b1;
				pulse_wdg;
				measure;
				chk_cnt(oe_len, 281, 293);
				fetch_check;
			end
			for (int i = 0; i < 5; i++) begin
				en = (i < 4);
				sel = (i < 4) ? i[1:0] : 2'($urandom);
				tick(40);
				run_len(1'b1, h);
				run_len(1'b0, l);
				chk_cnt(h, l, l);
				chk_cnt(h, en ? (1 << sel) : 1, en ? (3 << sel) : 3);
				k = (m ? 3 : 1) << (en ? sel : 2'h0);
				chk_cnt(h, k, k);
			end
		end
		final_report;
	end
endmodule
